// [cic_pkg.sv]
// Shared constants, carriers and state types of the cascaded interrupt controller
package cic_pkg;

  // ----------------------------------------------------------------
  // Port addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] CIC_MASTER_EVEN = 16'h0020;
  localparam logic [15:0] CIC_MASTER_ODD = 16'h0021;
  localparam logic [15:0] CIC_SLAVE_EVEN = 16'h00a0;
  localparam logic [15:0] CIC_SLAVE_ODD = 16'h00a1;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CIC_W1_SEL = 4;
  localparam int CIC_W1_LEVEL = 3;
  localparam int CIC_W1_INTERVAL = 2;
  localparam int CIC_OP_SEL = 3;
  localparam int CIC_W4_NESTED = 4;
  localparam int CIC_W4_AUTO = 1;
  localparam int CIC_SMM_HI = 6;
  localparam int CIC_SMM_LO = 5;
  localparam int CIC_POLL = 2;
  localparam int CIC_EOI_HI = 7;
  localparam int CIC_EOI_LO = 5;
  localparam int CIC_LVL_HI = 2;
  localparam int CIC_BASE_LO = 3;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CIC_EOI_CLR_ROT = 3'h0;
  localparam logic [2:0] CIC_EOI_NONSPEC = 3'h1;
  localparam logic [2:0] CIC_EOI_NOP = 3'h2;
  localparam logic [2:0] CIC_EOI_SPEC = 3'h3;
  localparam logic [2:0] CIC_EOI_SET_ROT = 3'h4;
  localparam logic [2:0] CIC_EOI_ROT_NONSPEC = 3'h5;
  localparam logic [2:0] CIC_EOI_SET_PRIO = 3'h6;
  localparam logic [2:0] CIC_EOI_ROT_SPEC = 3'h7;
  localparam logic [1:0] CIC_SMM_SET = 2'h3;
  localparam logic [1:0] CIC_SMM_CLR = 2'h2;
  localparam logic [1:0] CIC_RD_REQ = 2'h2;
  localparam logic [1:0] CIC_RD_SRV = 2'h3;
  localparam logic [2:0] CIC_SPURIOUS = 3'h7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CIC_MASK_RESET = 8'hff;
  localparam logic [2:0] CIC_LOWEST_RESET = 3'h7;

  typedef enum logic [1:0]
  {
    CIC_RUN = 2'b00,
    CIC_W2 = 2'b01,
    CIC_W3 = 2'b10,
    CIC_W4 = 2'b11
  } cic_step_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cic_io_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } cic_io_rsp_t;

  typedef struct packed {
    logic intr;
    logic vector_valid;
    logic [7:0] vector;
  } cic_cpu_t;

  typedef struct packed {
    cic_step_t step;
    logic level_mode;
    logic interval4;
    logic [4:0] base;
    logic [7:0] cascade;
    logic nested;
    logic automatic_end_of_interrupt;
    logic [7:0] mask;
    logic [7:0] irr;
    logic [7:0] isr;
    logic [2:0] lowest;
    logic rotate_aeoi;
    logic smm;
    logic read_isr;
    logic poll;
    logic [7:0] prev;
  } cic_unit_t;

  typedef struct packed {
    cic_unit_t [1:0] unit;
    cic_io_rsp_t rsp;
    cic_cpu_t cpu;
  } cic_state_t;

  localparam cic_unit_t CIC_UNIT_RESET = '{
    step: CIC_RUN, level_mode: 1'b0, interval4: 1'b0, base: 5'h00, cascade: 8'h00,
    nested: 1'b0, automatic_end_of_interrupt: 1'b0, mask: CIC_MASK_RESET, irr: 8'h00, isr: 8'h00,
    lowest: CIC_LOWEST_RESET, rotate_aeoi: 1'b0, smm: 1'b0, read_isr: 1'b0,
    poll: 1'b0, prev: 8'h00};

  localparam cic_state_t CIC_STATE_RESET = '{
    unit: {CIC_UNIT_RESET, CIC_UNIT_RESET}, rsp: '0, cpu: '0};

  // Level that sits at a given priority rank, rank 0 highest
  function automatic logic [2:0] cic_level(logic [2:0] rank, logic [2:0] lowest);
    return 3'(lowest + 3'd1 + rank);
  endfunction : cic_level

endpackage : cic_pkg

// [cic_sync.sv]
// Two-stage synchroniser for the request pins
`timescale 1ns/1ns
module cic_sync
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [15:0] pin,
  output logic [15:0] level
);
  import cic_pkg::*;

  typedef struct packed {
    logic [15:0] s1;
    logic [15:0] s2;
  } cic_sync_state_t;

  cic_sync_state_t st;
  cic_sync_state_t next_st;

  always_comb
  begin
    next_st.s1 = pin;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign level = st.s2;

endmodule : cic_sync

// [cic_resolver.sv]
// Priority resolver: best eligible request and highest level in service
`timescale 1ns/1ns
module cic_resolver
(
  input wire logic [7:0] req,
  input wire logic [7:0] isr,
  input wire logic [2:0] lowest,
  input wire logic smm,
  input wire logic nested,
  output logic hit,
  output logic [2:0] level,
  output logic isr_hit,
  output logic [2:0] isr_level
);
  import cic_pkg::*;

  logic [3:0] top_rank;
  logic [2:0] lvl;

  always_comb
  begin
    isr_hit = 1'b0;
    isr_level = 3'h0;
    top_rank = 4'h8;
    hit = 1'b0;
    level = 3'h0;
    lvl = 3'h0;
    // Scan from lowest rank so the highest one wins last
    for (int r = 7; r >= 0; r--)
    begin
      lvl = cic_level(3'(r), lowest);
      if (isr[lvl])
      begin
        isr_hit = 1'b1;
        isr_level = lvl;
        top_rank = 4'(r);
      end
    end
    for (int r = 7; r >= 0; r--)
    begin
      lvl = cic_level(3'(r), lowest);
      if (req[lvl])
      begin
        // Special mask lets any level not itself in service through
        if (smm ? !isr[lvl] : (4'(r) < top_rank || (nested && 4'(r) == top_rank)))
        begin
          hit = 1'b1;
          level = lvl;
        end
      end
    end
  end

endmodule : cic_resolver

// [cic_top.sv]
// Master and slave interrupt controller pair with port decode and CPU handshake
`timescale 1ns/1ns

// Notes on behaviour
// - Master at ports 020h/021h, slave at 0A0h/0A1h, each decodes its own words.
// - First init word bit 3 picks edge or level; bit 2 is stored but does not change vector spacing.
// - Next three odd-port writes are init words two, three, four; then masks.
// - Second init word bits 7:3 give the base vector; low bits zero.
// - Fourth word bit 4 fully nested, bit 1 automatic end of interrupt.
// - Odd port outside init holds readable mask; one blocks an input.
// - End-of-interrupt command bits 7:5 select rotate, end, priority operations.
// - Specific, set-priority and specific-rotate codes act on level bits 2:0.
// - Operation word bits 6:5: 11 enters, 10 leaves special mask mode.
// - Bit 2 polls; bits 1:0 select request or in-service for reads.
// - Even-port read returns the last selected request or in-service register.
// - Request register reads zero for pending, one for not pending.
// - In-service register reads one while that level is serviced.
module cic_top
(
  input wire logic core_clk,
  input wire logic srst,
  input cic_pkg::cic_io_req_t io_req,
  output cic_pkg::cic_io_rsp_t io_rsp,
  input wire logic [15:0] irq_pin,
  input wire logic cpu_inta,
  output cic_pkg::cic_cpu_t cpu
);
  import cic_pkg::*;

  cic_state_t st;
  cic_state_t next_st;

  logic [15:0] irq_level;
  logic [1:0] hit;
  logic [1:0][2:0] lvl;
  logic [1:0] isr_hit;
  logic [1:0][2:0] isr_lvl;
  logic [1:0][7:0] raw;
  logic [1:0] sel_even;
  logic [1:0] sel_odd;

  // ----------------------------------------------------------------
  // Request inputs and resolvers
  // ----------------------------------------------------------------
  cic_sync u_sync
  (
    .core_clk(core_clk),
    .srst(srst),
    .pin(irq_pin),
    .level(irq_level)
  );

  always_comb
  begin
    raw[1] = irq_level[15:8];
    // Cascade input of the master follows the slave's pending state
    raw[0] = {irq_level[7:3], hit[1], irq_level[1:0]};
    sel_even[0] = io_req.addr == CIC_MASTER_EVEN;
    sel_odd[0] = io_req.addr == CIC_MASTER_ODD;
    sel_even[1] = io_req.addr == CIC_SLAVE_EVEN;
    sel_odd[1] = io_req.addr == CIC_SLAVE_ODD;
  end

  for (genvar u = 0; u < 2; u++)
  begin : g_res
    cic_resolver u_res
    (
      .req(st.unit[u].irr & ~st.unit[u].mask),
      .isr(st.unit[u].isr),
      .lowest(st.unit[u].lowest),
      .smm(st.unit[u].smm),
      .nested(st.unit[u].nested),
      .hit(hit[u]),
      .level(lvl[u]),
      .isr_hit(isr_hit[u]),
      .isr_level(isr_lvl[u])
    );
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Acknowledge a level: mark in service or end at once in auto mode
  function automatic cic_unit_t cic_take(cic_unit_t un, logic [2:0] l);
    cic_unit_t r;
    r = un;
    if (un.automatic_end_of_interrupt)
    begin
      if (un.rotate_aeoi)
      begin
        r.lowest = l;
      end
    end
    else
    begin
      r.isr[l] = 1'b1;
    end
    if (!un.level_mode)
    begin
      r.irr[l] = 1'b0;
    end
    return r;
  endfunction : cic_take

  // Decode one end-of-interrupt command
  function automatic cic_unit_t cic_eoi(cic_unit_t un, logic [7:0] d, logic top_ok,
                                       logic [2:0] top);
    cic_unit_t r;
    logic [2:0] l;
    r = un;
    l = d[CIC_LVL_HI:0];
    case (d[CIC_EOI_HI:CIC_EOI_LO])
      CIC_EOI_CLR_ROT: r.rotate_aeoi = 1'b0;
      CIC_EOI_SET_ROT: r.rotate_aeoi = 1'b1;
      CIC_EOI_NONSPEC:
      begin
        if (top_ok)
        begin
          r.isr[top] = 1'b0;
        end
      end
      CIC_EOI_ROT_NONSPEC:
      begin
        if (top_ok)
        begin
          r.isr[top] = 1'b0;
          r.lowest = top;
        end
      end
      CIC_EOI_SPEC: r.isr[l] = 1'b0;
      CIC_EOI_SET_PRIO: r.lowest = l;
      CIC_EOI_ROT_SPEC:
      begin
        r.isr[l] = 1'b0;
        r.lowest = l;
      end
      CIC_EOI_NOP: r = un;
      default: r = un;
    endcase
    return r;
  endfunction : cic_eoi

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    cic_unit_t un;
    logic [7:0] d;
    logic [7:0] rise;
    logic [2:0] s_lvl;
    un = '0;
    d = io_req.wdata;
    rise = 8'h00;
    s_lvl = 3'h0;
    next_st = st;
    next_st.rsp.valid = 1'b0;
    next_st.cpu.vector_valid = 1'b0;

    // CPU acknowledge: master picks, cascade level hands over to the slave
    if (cpu_inta)
    begin
      next_st.cpu.vector_valid = 1'b1;
      if (!hit[0])
      begin
        next_st.cpu.vector = {st.unit[0].base, CIC_SPURIOUS};
      end
      else
      begin
        next_st.unit[0] = cic_take(st.unit[0], lvl[0]);
        if (st.unit[0].cascade[lvl[0]])
        begin
          s_lvl = hit[1] ? lvl[1] : CIC_SPURIOUS;
          if (hit[1])
          begin
            next_st.unit[1] = cic_take(st.unit[1], lvl[1]);
          end
          next_st.cpu.vector = {st.unit[1].base, s_lvl};
        end
        else
        begin
          next_st.cpu.vector = {st.unit[0].base, lvl[0]};
        end
      end
    end

    for (int u = 0; u < 2; u++)
    begin
      un = next_st.unit[u];

      // Register reads
      if (io_req.rd && (sel_even[u] || sel_odd[u]))
      begin
        next_st.rsp.valid = 1'b1;
        if (sel_odd[u])
        begin
          next_st.rsp.data = st.unit[u].mask;
        end
        else if (st.unit[u].poll)
        begin
          // Poll read doubles as an acknowledge
          next_st.rsp.data = {hit[u], 4'h0, lvl[u]};
          un.poll = 1'b0;
          if (hit[u])
          begin
            un = cic_take(un, lvl[u]);
          end
        end
        else if (st.unit[u].read_isr)
        begin
          next_st.rsp.data = st.unit[u].isr;
        end
        else
        begin
          next_st.rsp.data = ~st.unit[u].irr;
        end
      end

      // Register writes
      if (io_req.wr && sel_even[u])
      begin
        if (d[CIC_W1_SEL])
        begin
          un = CIC_UNIT_RESET;
          un.level_mode = d[CIC_W1_LEVEL];
          un.interval4 = d[CIC_W1_INTERVAL];
          un.mask = 8'h00;
          un.prev = st.unit[u].prev;
          un.step = CIC_W2;
        end
        else if (!d[CIC_OP_SEL])
        begin
          un = cic_eoi(un, d, isr_hit[u], isr_lvl[u]);
          // Acknowledge in the same cycle keeps its in-service bit
          un.isr = un.isr | (next_st.unit[u].isr & ~st.unit[u].isr);
        end
        else
        begin
          if (d[CIC_SMM_HI:CIC_SMM_LO] == CIC_SMM_SET)
          begin
            un.smm = 1'b1;
          end
          else if (d[CIC_SMM_HI:CIC_SMM_LO] == CIC_SMM_CLR)
          begin
            un.smm = 1'b0;
          end
          if (d[1:0] == CIC_RD_REQ)
          begin
            un.read_isr = 1'b0;
          end
          else if (d[1:0] == CIC_RD_SRV)
          begin
            un.read_isr = 1'b1;
          end
          un.poll = d[CIC_POLL];
        end
      end
      else if (io_req.wr && sel_odd[u])
      begin
        case (st.unit[u].step)
          CIC_W2:
          begin
            un.base = d[7:CIC_BASE_LO];
            un.step = CIC_W3;
          end
          CIC_W3:
          begin
            un.cascade = d;
            un.step = CIC_W4;
          end
          CIC_W4:
          begin
            un.nested = d[CIC_W4_NESTED];
            un.automatic_end_of_interrupt = d[CIC_W4_AUTO];
            un.step = CIC_RUN;
          end
          CIC_RUN: un.mask = d;
          default: un.step = CIC_RUN;
        endcase
      end

      // Request capture; a new edge wins over a same-cycle clear
      rise = raw[u] & ~st.unit[u].prev;
      if (un.level_mode)
      begin
        un.irr = raw[u];
      end
      else
      begin
        un.irr = (un.irr | rise) & raw[u];
      end
      un.prev = raw[u];
      next_st.unit[u] = un;
    end

    next_st.cpu.intr = hit[0];
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      st <= CIC_STATE_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign io_rsp = st.rsp;
  assign cpu = st.cpu;

endmodule : cic_top

// [cic_assertions.sv]
// Port-level checks for the cascaded interrupt controller
`timescale 1ns/1ns
module cic_assertions
(
  input wire logic core_clk,
  input wire logic srst,
  input cic_pkg::cic_io_req_t io_req,
  input cic_pkg::cic_io_rsp_t io_rsp,
  input wire logic [15:0] irq_pin,
  input wire logic cpu_inta,
  input cic_pkg::cic_cpu_t cpu
);
  import cic_pkg::*;
  logic mapped;
  assign mapped = io_req.addr inside {CIC_MASTER_EVEN, CIC_MASTER_ODD, CIC_SLAVE_EVEN,
    CIC_SLAVE_ODD};
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (srst);

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  property p_rd_answer;
    io_req.rd && mapped |=> io_rsp.valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("mapped read gave no answer");
  property p_unmapped_quiet;
    io_req.rd && !mapped |=> !io_rsp.valid;
  endproperty
  a_unmapped_quiet: assert property (p_unmapped_quiet) else $error("unmapped read answered");
  property p_valid_pulse;
    !io_req.rd |=> !io_rsp.valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("answer without read");
  property p_data_hold;
    !io_req.rd |=> $stable(io_rsp.data);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("read data moved");

  // ----------------------------------------------------------------
  // Processor side
  // ----------------------------------------------------------------
  property p_inta_vector;
    cpu_inta |=> cpu.vector_valid;
  endproperty
  a_inta_vector: assert property (p_inta_vector) else $error("no vector after ack");
  property p_vector_pulse;
    !cpu_inta |=> !cpu.vector_valid;
  endproperty
  a_vector_pulse: assert property (p_vector_pulse) else $error("vector without ack");
  property p_vector_hold;
    !cpu_inta |=> $stable(cpu.vector);
  endproperty
  a_vector_hold: assert property (p_vector_hold) else $error("vector moved");
  property p_mask_reset;
    $fell(srst) ##0 (!io_req.wr) [*4] |-> !cpu.intr;
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("request passed reset mask");

  c_read: cover property (io_req.rd && mapped ##1 io_rsp.valid);
  c_ack: cover property (cpu_inta ##1 cpu.vector_valid);
  c_intr: cover property ($rose(cpu.intr));
endmodule : cic_assertions

bind cic_top cic_assertions i_chk (.core_clk(core_clk), .srst(srst), .io_req(io_req),
  .io_rsp(io_rsp), .irq_pin(irq_pin), .cpu_inta(cpu_inta), .cpu(cpu));

// [cic_partner.sv]
// Behavioural processor core and request sources
`timescale 1ns/1ns
module cic_partner
(
  input wire logic core_clk,
  input wire logic [15:0] src,
  input wire logic ack_en,
  input wire logic [2:0] ack_wait,
  input cic_pkg::cic_cpu_t cpu,
  output logic [15:0] irq_pin,
  output logic cpu_inta,
  output logic [7:0] vec,
  output logic seen
);
  import cic_pkg::*;
  logic [15:0] pin_q = 16'h0000;
  logic inta_q = 1'b0;
  logic [7:0] vec_q = 8'h00;
  logic seen_q = 1'b0;
  int cnt = 0;
  int w = 0;
  assign irq_pin = pin_q;
  assign cpu_inta = inta_q;
  assign vec = vec_q;
  assign seen = seen_q;
  // Cool-down lets the request line settle before the next ack
  always @(negedge core_clk)
  begin
    pin_q <= src;
    inta_q <= 1'b0;
    seen_q <= cpu.vector_valid;
    if (cpu.vector_valid)
    begin
      vec_q <= cpu.vector;
    end
    w <= cpu.intr ? w + 1 : 0;
    if (cnt > 0)
    begin
      cnt <= cnt - 1;
    end
    else if (ack_en && cpu.intr && w >= int'(ack_wait))
    begin
      inta_q <= 1'b1;
      cnt <= 3;
    end
  end
endmodule : cic_partner

// [cic_top_tb.sv]
// Self-checking bench for the cascaded interrupt controller
`timescale 1ns/1ns
module cic_top_tb;
  import cic_pkg::*;
  logic core_clk;
  logic srst;
  cic_io_req_t req;
  cic_io_rsp_t rsp;
  cic_cpu_t cpu;
  logic [15:0] irq_pin;
  logic [15:0] src;
  logic cpu_inta;
  logic ack_en;
  logic [2:0] ack_wait;
  logic [7:0] vec;
  logic seen;
  int num_errors = 0;
  int compares = 0;

  cic_top i_dut (.core_clk(core_clk), .srst(srst), .io_req(req), .io_rsp(rsp),
    .irq_pin(irq_pin), .cpu_inta(cpu_inta), .cpu(cpu));
  cic_partner i_cpu (.core_clk(core_clk), .src(src), .ack_en(ack_en), .ack_wait(ack_wait),
    .cpu(cpu), .irq_pin(irq_pin), .cpu_inta(cpu_inta), .vec(vec), .seen(seen));

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e)
    begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (num_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge core_clk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = v;
    @(negedge core_clk);
    req.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic ok, input logic [7:0] e);
    @(negedge core_clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge core_clk);
    req.rd = 1'b0;
    chk({7'h00, rsp.valid}, {7'h00, ok});
    if (ok)
      chk(rsp.data, e);
  endtask : rd

  task automatic init(input logic [15:0] a, input logic [7:0] w1, input logic [7:0] o);
    wr(a, w1);
    wr(a + 16'h1, (a == CIC_MASTER_EVEN) ? 8'h08 : 8'h70);
    wr(a + 16'h1, (a == CIC_MASTER_EVEN) ? 8'h04 : 8'h02);
    wr(a + 16'h1, o);
  endtask : init

  task automatic take(input logic [7:0] e);
    int i;
    for (i = 0; i < 40; i++)
    begin
      @(posedge core_clk);
      if (seen === 1'b1)
        break;
    end
    if (i == 40)
    begin
      num_errors++;
      $display("Error at %0t: no vector within limit", $time);
      tally_and_finish();
    end
    else
    begin
      chk(vec, e);
    end
  endtask : take

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd(CIC_MASTER_ODD, 1'b1, 8'hff);
    rd(CIC_SLAVE_ODD, 1'b1, 8'hff);
    rd(CIC_MASTER_EVEN, 1'b1, 8'hff);
    rd(16'h0022, 1'b0, 8'h00);
    init(CIC_MASTER_EVEN, 8'h11, 8'h01);
    init(CIC_SLAVE_EVEN, 8'h11, 8'h01);
    rd(CIC_MASTER_ODD, 1'b1, 8'h00);
    wr(CIC_SLAVE_ODD, 8'h5a);
    rd(CIC_SLAVE_ODD, 1'b1, 8'h5a);
    rd(CIC_MASTER_ODD, 1'b1, 8'h00);
    wr(CIC_SLAVE_ODD, 8'h00);
  endtask : t_regs

  task automatic t_vec();
    src = 16'h0020;
    repeat (6) @(negedge core_clk);
    rd(CIC_MASTER_EVEN, 1'b1, 8'hdf);
    ack_en = 1'b1;
    take(8'h0d);
    wr(CIC_MASTER_EVEN, 8'h0b);
    rd(CIC_MASTER_EVEN, 1'b1, 8'h20);
    wr(CIC_MASTER_EVEN, 8'h0a);
    rd(CIC_MASTER_EVEN, 1'b1, 8'hff);
    wr(CIC_MASTER_EVEN, 8'h65);
    wr(CIC_MASTER_EVEN, 8'h0b);
    rd(CIC_MASTER_EVEN, 1'b1, 8'h00);
    src = 16'h0000;
  endtask : t_vec

  task automatic t_slave();
    ack_wait = 3'h3;
    src = 16'h0400;
    take(8'h72);
    wr(CIC_SLAVE_EVEN, 8'h0b);
    rd(CIC_SLAVE_EVEN, 1'b1, 8'h04);
    rd(CIC_MASTER_EVEN, 1'b1, 8'h04);
    src = 16'h0000;
    wr(CIC_SLAVE_EVEN, 8'h20);
    wr(CIC_MASTER_EVEN, 8'h20);
    rd(CIC_MASTER_EVEN, 1'b1, 8'h00);
    ack_wait = 3'h0;
  endtask : t_slave

  task automatic t_prio();
    wr(CIC_MASTER_EVEN, 8'hc4);
    src = 16'h0042;
    take(8'h0e);
    wr(CIC_MASTER_EVEN, 8'h68);
    wr(CIC_MASTER_ODD, 8'h40);
    take(8'h09);
    @(negedge core_clk);
    src = 16'h0000;
    wr(CIC_MASTER_EVEN, 8'h48);
    wr(CIC_MASTER_ODD, 8'h00);
    wr(CIC_MASTER_EVEN, 8'he6);
    wr(CIC_MASTER_EVEN, 8'ha0);
    rd(CIC_MASTER_EVEN, 1'b1, 8'h00);
    wr(CIC_MASTER_EVEN, 8'hc7);
  endtask : t_prio

  task automatic t_poll();
    ack_en = 1'b0;
    src = 16'h0010;
    repeat (6) @(negedge core_clk);
    chk({7'h00, cpu.intr}, 8'h01);
    wr(CIC_MASTER_EVEN, 8'h0c);
    rd(CIC_MASTER_EVEN, 1'b1, 8'h84);
    src = 16'h0000;
    wr(CIC_MASTER_EVEN, 8'h20);
    ack_en = 1'b1;
  endtask : t_poll

  task automatic t_auto();
    init(CIC_MASTER_EVEN, 8'h11, 8'h03);
    wr(CIC_MASTER_EVEN, 8'h80);
    wr(CIC_MASTER_EVEN, 8'h40);
    wr(CIC_MASTER_EVEN, 8'h00);
    src = 16'h0080;
    take(8'h0f);
    wr(CIC_MASTER_EVEN, 8'h0b);
    rd(CIC_MASTER_EVEN, 1'b1, 8'h00);
    src = 16'h0000;
  endtask : t_auto

  task automatic t_level();
    init(CIC_MASTER_EVEN, 8'h19, 8'h11);
    src = 16'h0008;
    take(8'h0b);
    rd(CIC_MASTER_EVEN, 1'b1, 8'hf7);
    chk({7'h00, cpu.intr}, 8'h01);
    src = 16'h0000;
    repeat (6) @(negedge core_clk);
    rd(CIC_MASTER_EVEN, 1'b1, 8'hff);
    wr(CIC_MASTER_EVEN, 8'h20);
  endtask : t_level

  task automatic t_reset();
    srst = 1'b1;
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    rd(CIC_MASTER_ODD, 1'b1, 8'hff);
    rd(CIC_SLAVE_ODD, 1'b1, 8'hff);
  endtask : t_reset

  initial
  begin
    req = '0;
    src = 16'h0000;
    ack_en = 1'b0;
    ack_wait = 3'h0;
    srst = 1'b1;
    repeat (4) @(negedge core_clk);
    srst = 1'b0;
    t_regs();
    t_vec();
    t_slave();
    t_prio();
    t_poll();
    t_auto();
    t_level();
    t_reset();
    tally_and_finish();
  end
endmodule : cic_top_tb
